//--- common/nvs_defines.svh
// Constants shared by both ends of the serial configuration link.
`ifndef NVS_DEFINES_SVH
`define NVS_DEFINES_SVH
`define NVS_CLK_NS 10
`define NVS_SCL_PERIOD_NS 2500
`define NVS_SCL_QTR_CYC ((`NVS_SCL_PERIOD_NS / 4 + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_WCYC_NS 10000
`define NVS_WCYC_CYC (`NVS_WCYC_NS / `NVS_CLK_NS)
`define NVS_NV_DEPTH 16
`define NVS_CFG_BYTES 12
`define NVS_PAGE_BYTES 4
`define NVS_SLAVE_BASE 6'h14
`define NVS_SHADOW_RST 8'h00
`define NVS_FIFO_DEPTH 4
`endif

//--- common/nvs_pkg.sv
// Types shared by both ends of the serial configuration link.
package nvs_pkg;
  typedef enum logic [2:0] {
    st_recall, st_idle, st_slave, st_addr, st_wdata, st_read, st_wcycle
  } dev_state_t;
  typedef enum logic [2:0] {
    h_idle, h_start, h_byte, h_wait, h_stop
  } host_state_t;
  typedef enum logic [2:0] {
    s_slave_w, s_addr, s_data_w, s_slave_r, s_data_r
  } host_step_t;
  typedef struct packed {
    logic fail;
    logic used;
    logic [7:0] data;
  } ecc_res_t;
endpackage : nvs_pkg

//--- common/nvs_if.sv
// Two-wire link between the bus master and the nonvolatile access slave.
`timescale 1ns/1ns
interface nvs_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic serial_data_out;
  logic serial_data_out_oe;
  logic serial_data_in;
  logic nonvolatile_select_bit;
  assign serial_data_in = !((host_sda_oe && !host_sda_out) ||
                            (serial_data_out_oe && !serial_data_out));
  modport host (output scl, output host_sda_out, output host_sda_oe,
                output nonvolatile_select_bit, input serial_data_in);
  modport dev (input scl, input serial_data_in, input nonvolatile_select_bit,
               output serial_data_out, output serial_data_out_oe);
endinterface : nvs_if

//--- rtl/nvs_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module nvs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  assign o_in_ready = cnt != (AW+1)'(DEPTH);
  assign o_out_valid = cnt != '0;
  assign o_out_data = mem[rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wp] <= i_in_data;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      case ({push, pop})
        2'h2: cnt <= cnt + 1'b1;
        2'h1: cnt <= cnt - 1'b1;
        default: cnt <= cnt;
      endcase
    end
  end
endmodule : nvs_fifo

//--- rtl/nvs_device.sv
// Serial slave giving access to shadow RAM and the ECC-protected array.
// How it works
// - Reset recall copies configuration bytes to shadow.
// - Select bit steers accesses to array or shadow.
// - Configuration output is read from shadow only.
// - Host writes array only in aligned pages.
// - Clean array read clears both ECC flags.
// - Single-bit error corrected, corrected flag set.
// - Double-bit error sets uncorrectable flag only.
// - Recall corrects singles, skips uncorrectable bytes.
// - Recall flags decide configuration valid before operation.
// - Next array read overwrites both ECC flags.
// - Separate data in and out, tie-able.
// - Bus clock at most 400 kHz.
// - Address-select pin picks slave address.
// - Master starts transfers and drives clock.
// - Bytes travel most significant bit first.
// - Data moves only while clock is low.
// - Ignore bus until a start condition.
// - Stop ends transfer and returns standby.
// - Receiver pulls data low on ninth clock.
// - Acknowledge matching slave byte and write bytes.
// - Read continues only on master acknowledge.
// - Page write address wraps inside page.
// - Write cycle after stop ignores the bus.
`timescale 1ns/1ns
`include "nvs_defines.svh"
module nvs_device (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  nvs_if.dev bus,
  input wire logic i_addr_sel,
  input wire logic i_nv_we,
  input wire logic [3:0] i_nv_addr,
  input wire logic [12:0] i_nv_word,
  input wire logic [3:0] i_cfg_addr,
  output logic [7:0] o_cfg_data,
  output logic o_cfg_valid,
  output logic o_recall_done,
  output logic o_ecc_corrected,
  output logic o_ecc_uncorrectable,
  output logic o_busy
);
  function automatic logic [12:0] ecc_enc(input logic [7:0] d);
    logic [12:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 3; i < 13; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k = k + 1;
      end
    end
    for (int p = 0; p < 4; p++) begin
      for (int i = 3; i < 13; i++) begin
        if (i[p] && ((i & (i - 1)) != 0)) begin
          c[1 << p] = c[1 << p] ^ c[i];
        end
      end
    end
    c[0] = ^c;
    return c;
  endfunction : ecc_enc

  function automatic nvs_pkg::ecc_res_t ecc_dec(input logic [12:0] w);
    logic [12:0] c;
    logic [3:0] s;
    nvs_pkg::ecc_res_t r;
    int k;
    c = w;
    s = '0;
    r = '0;
    k = 0;
    for (int p = 0; p < 4; p++) begin
      for (int i = 1; i < 13; i++) begin
        if (i[p]) begin
          s[p] = s[p] ^ c[i];
        end
      end
    end
    if (^c) begin
      if (s > 4'hC) begin
        r.fail = 1'h1;
      end else begin
        c[s] = !c[s];
        r.used = 1'h1;
      end
    end else if (s != 4'h0) begin
      r.fail = 1'h1;
    end
    for (int i = 3; i < 13; i++) begin
      if ((i & (i - 1)) != 0) begin
        r.data[k] = c[i];
        k = k + 1;
      end
    end
    return r;
  endfunction : ecc_dec

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] sel_q;
  logic [1:0] asel_q;
  nvs_pkg::dev_state_t state;
  logic [3:0] bitcnt;
  logic [3:0] ptr;
  logic [3:0] rc_addr;
  logic [7:0] rx;
  logic [7:0] tx;
  logic ack;
  logic mack;
  logic rc_bad;
  logic [15:0] wcnt;
  logic [12:0] nv [`NVS_NV_DEPTH];
  logic [7:0] shadow [`NVS_NV_DEPTH];
  logic [7:0] pg_data [`NVS_PAGE_BYTES];
  logic [3:0] pg_mask;
  logic [1:0] pg_base;
  nvs_pkg::ecc_res_t dec;
  logic [3:0] dec_addr;
  logic [7:0] rd_data;
  logic [6:0] my_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic active;
  logic byte_done;
  logic ack_done;
  logic wr_byte;
  logic rd_load;
  logic rc_last;
  logic wc_last;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      sel_q <= 2'h0;
      asel_q <= 2'h0;
    end else begin
      scl_q <= {scl_q[1:0], bus.scl};
      sda_q <= {sda_q[1:0], bus.serial_data_in};
      sel_q <= {sel_q[0], bus.nonvolatile_select_bit};
      asel_q <= {asel_q[0], i_addr_sel};
    end
  end

  assign scl_rise = scl_q[1] && !scl_q[2];
  assign scl_fall = !scl_q[1] && scl_q[2];
  assign start_c = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
  assign stop_c = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];
  assign my_addr = {`NVS_SLAVE_BASE, asel_q[1]};
  assign active = (state == nvs_pkg::st_slave) || (state == nvs_pkg::st_addr) ||
                  (state == nvs_pkg::st_wdata) || (state == nvs_pkg::st_read);
  assign dec_addr = (state == nvs_pkg::st_recall) ? rc_addr : ptr;
  assign dec = ecc_dec(nv[dec_addr]);
  assign rd_data = sel_q[1] ? dec.data : shadow[ptr];
  assign byte_done = active && scl_fall && (bitcnt == 4'h7);
  assign ack_done = active && scl_fall && (bitcnt == 4'h8);
  assign wr_byte = byte_done && (state == nvs_pkg::st_wdata);
  assign rd_load = ack_done && (state == nvs_pkg::st_read) && mack;
  assign rc_last = rc_addr == 4'(`NVS_CFG_BYTES - 1);
  assign wc_last = wcnt == 16'(`NVS_WCYC_CYC - 1);
  assign bus.serial_data_out = 1'h0;
  assign bus.serial_data_out_oe = ack || ((state == nvs_pkg::st_read) &&
                                  (bitcnt != 4'h8) && !tx[7]);
  assign o_busy = state == nvs_pkg::st_wcycle;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= nvs_pkg::st_recall;
      bitcnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      ack <= 1'h0;
      mack <= 1'h0;
      ptr <= 4'h0;
      rc_addr <= 4'h0;
      wcnt <= 16'h0000;
    end else begin
      case (state)
        nvs_pkg::st_recall: begin
          rc_addr <= rc_addr + 4'h1;
          if (rc_last) begin
            state <= nvs_pkg::st_idle;
          end
        end
        nvs_pkg::st_wcycle: begin
          wcnt <= wcnt + 16'h0001;
          if (wc_last) begin
            wcnt <= 16'h0000;
            state <= nvs_pkg::st_idle;
          end
        end
        default: begin
          if (start_c) begin
            state <= nvs_pkg::st_slave;
            bitcnt <= 4'hF; // The fall after a start wraps this to zero.
            ack <= 1'h0;
          end else if (stop_c) begin
            state <= (pg_mask != 4'h0) ? nvs_pkg::st_wcycle
                                       : nvs_pkg::st_idle;
            ack <= 1'h0;
          end else if (active) begin
            if (scl_rise && (bitcnt != 4'h8)) begin
              rx <= {rx[6:0], sda_q[1]};
            end
            if (scl_rise && (bitcnt == 4'h8)) begin
              mack <= !sda_q[1];
            end
            if (scl_fall) begin
              bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                case (state)
                  nvs_pkg::st_slave: begin
                    if (rx[7:1] == my_addr) begin
                      ack <= 1'h1;
                      mack <= 1'h1;
                      state <= rx[0] ? nvs_pkg::st_read : nvs_pkg::st_addr;
                    end else begin
                      state <= nvs_pkg::st_idle;
                    end
                  end
                  nvs_pkg::st_addr: begin
                    ack <= 1'h1;
                    ptr <= rx[3:0];
                    state <= nvs_pkg::st_wdata;
                  end
                  nvs_pkg::st_wdata: begin
                    ack <= 1'h1;
                    ptr <= {ptr[3:2], ptr[1:0] + 2'h1};
                  end
                  default: ack <= 1'h0;
                endcase
              end else if (bitcnt == 4'h8) begin
                ack <= 1'h0;
                if (state == nvs_pkg::st_read) begin
                  if (mack) begin
                    tx <= rd_data;
                    ptr <= ptr + 4'h1;
                  end else begin
                    state <= nvs_pkg::st_idle;
                  end
                end
              end else begin
                tx <= {tx[6:0], 1'h0};
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_ecc_corrected <= 1'h0;
      o_ecc_uncorrectable <= 1'h0;
    end else if ((state == nvs_pkg::st_recall) || (rd_load && sel_q[1])) begin
      o_ecc_corrected <= dec.used;
      o_ecc_uncorrectable <= dec.fail;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rc_bad <= 1'h0;
      o_recall_done <= 1'h0;
      o_cfg_valid <= 1'h0;
    end else if (state == nvs_pkg::st_recall) begin
      rc_bad <= rc_bad || dec.fail;
      if (rc_last) begin
        o_recall_done <= 1'h1;
        o_cfg_valid <= !(rc_bad || dec.fail);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < `NVS_NV_DEPTH; i++) begin
        shadow[i] <= `NVS_SHADOW_RST;
      end
    end else if ((state == nvs_pkg::st_recall) && !dec.fail) begin
      shadow[rc_addr] <= dec.data;
    end else if (wr_byte && !sel_q[1] && (ptr < 4'(`NVS_CFG_BYTES))) begin
      shadow[ptr] <= rx;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pg_mask <= 4'h0;
      pg_base <= 2'h0;
      for (int i = 0; i < `NVS_PAGE_BYTES; i++) begin
        pg_data[i] <= 8'h00;
      end
    end else if (wr_byte && sel_q[1]) begin
      pg_data[ptr[1:0]] <= rx;
      pg_mask[ptr[1:0]] <= 1'h1;
      pg_base <= ptr[3:2];
    end else if ((state == nvs_pkg::st_wcycle) && wc_last) begin
      pg_mask <= 4'h0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_nv_we) begin
      nv[i_nv_addr] <= i_nv_word;
    end else if ((state == nvs_pkg::st_wcycle) && (wcnt == 16'h0000)) begin
      for (int i = 0; i < `NVS_PAGE_BYTES; i++) begin
        if (pg_mask[i]) begin
          nv[{pg_base, 2'(i)}] <= ecc_enc(pg_data[i]);
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_cfg_data <= 8'h00;
    end else begin
      o_cfg_data <= shadow[i_cfg_addr];
    end
  end
endmodule : nvs_device

//--- rtl/nvs_host.sv
// Bus master that runs write and random read transfers on the link.
`timescale 1ns/1ns
`include "nvs_defines.svh"
module nvs_host (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  nvs_if.host bus,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_read,
  input wire logic i_req_nv,
  input wire logic [6:0] i_req_slave,
  input wire logic [7:0] i_req_addr,
  input wire logic [2:0] i_req_count,
  input wire logic i_wdata_valid,
  output logic o_wdata_ready,
  input wire logic [7:0] i_wdata,
  output logic o_rdata_valid,
  output logic [7:0] o_rdata,
  output logic o_nack,
  output logic o_done
);
  nvs_pkg::host_state_t state;
  nvs_pkg::host_step_t step;
  logic [7:0] qcnt;
  logic [1:0] ph;
  logic [3:0] bi;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [2:0] cnt;
  logic [6:0] slave;
  logic [7:0] addr;
  logic rd;
  logic ack_ok;
  logic [1:0] sq;
  logic tick;
  logic f_valid;
  logic f_pop;
  logic [7:0] f_data;
  logic next_scl;
  logic next_oe;

  nvs_fifo #(.WIDTH(8), .DEPTH(`NVS_FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_wdata_valid),
    .o_in_ready(o_wdata_ready),
    .i_in_data(i_wdata),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_data)
  );

  assign tick = qcnt == 8'(`NVS_SCL_QTR_CYC - 1);
  assign o_req_ready = state == nvs_pkg::h_idle;
  assign f_pop = (state == nvs_pkg::h_wait) && f_valid;
  assign bus.host_sda_out = 1'h0;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sq <= 2'h3;
      qcnt <= 8'h00;
    end else begin
      sq <= {sq[0], bus.serial_data_in};
      if ((state == nvs_pkg::h_idle) || (state == nvs_pkg::h_wait) || tick) begin
        qcnt <= 8'h00;
      end else begin
        qcnt <= qcnt + 8'h01;
      end
    end
  end

  always_comb begin
    next_scl = 1'h1;
    next_oe = 1'h0;
    case (state)
      nvs_pkg::h_start: begin
        next_scl = (ph == 2'h1) || (ph == 2'h2);
        next_oe = ph[1];
      end
      nvs_pkg::h_byte: begin
        next_scl = (ph == 2'h1) || (ph == 2'h2);
        if (bi != 4'h8) begin
          next_oe = (step != nvs_pkg::s_data_r) && !tx[7];
        end else begin
          next_oe = (step == nvs_pkg::s_data_r) && (cnt != 3'h1);
        end
      end
      nvs_pkg::h_wait: next_scl = 1'h0;
      nvs_pkg::h_stop: begin
        next_scl = ph != 2'h0;
        next_oe = !ph[1];
      end
      default: next_scl = 1'h1;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      bus.scl <= 1'h1;
      bus.host_sda_oe <= 1'h0;
    end else begin
      bus.scl <= next_scl;
      bus.host_sda_oe <= next_oe;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= nvs_pkg::h_idle;
      step <= nvs_pkg::s_slave_w;
      ph <= 2'h0;
      bi <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      cnt <= 3'h0;
      slave <= 7'h00;
      addr <= 8'h00;
      rd <= 1'h0;
      ack_ok <= 1'h0;
      o_rdata <= 8'h00;
      o_rdata_valid <= 1'h0;
      o_nack <= 1'h0;
      o_done <= 1'h0;
      bus.nonvolatile_select_bit <= 1'h0;
    end else begin
      o_rdata_valid <= 1'h0;
      o_done <= 1'h0;
      case (state)
        nvs_pkg::h_idle: begin
          if (i_req_valid) begin
            bus.nonvolatile_select_bit <= i_req_nv;
            slave <= i_req_slave;
            addr <= i_req_addr;
            rd <= i_req_read;
            cnt <= (i_req_count == 3'h0) ? 3'h1 : i_req_count;
            o_nack <= 1'h0;
            step <= nvs_pkg::s_slave_w;
            ph <= 2'h0;
            state <= nvs_pkg::h_start;
          end
        end
        nvs_pkg::h_start: begin
          if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
              tx <= {slave, step == nvs_pkg::s_slave_r};
              bi <= 4'h0;
              state <= nvs_pkg::h_byte;
            end
          end
        end
        nvs_pkg::h_wait: begin
          if (f_valid) begin
            tx <= f_data;
            bi <= 4'h0;
            ph <= 2'h0;
            state <= nvs_pkg::h_byte;
          end
        end
        nvs_pkg::h_stop: begin
          if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
              o_done <= 1'h1;
              state <= nvs_pkg::h_idle;
            end
          end
        end
        nvs_pkg::h_byte: begin
          if (tick) begin
            ph <= ph + 2'h1;
            if ((ph == 2'h2) && (bi != 4'h8)) begin
              rx <= {rx[6:0], sq[1]};
            end
            if ((ph == 2'h2) && (bi == 4'h8)) begin
              ack_ok <= !sq[1];
            end
            if ((ph == 2'h3) && (bi != 4'h8)) begin
              bi <= bi + 4'h1;
              tx <= {tx[6:0], 1'h0};
            end
            if ((ph == 2'h3) && (bi == 4'h8)) begin
              bi <= 4'h0;
              if ((step != nvs_pkg::s_data_r) && !ack_ok) begin
                o_nack <= 1'h1;
                state <= nvs_pkg::h_stop;
              end else begin
                case (step)
                  nvs_pkg::s_slave_w: begin
                    step <= nvs_pkg::s_addr;
                    tx <= addr;
                  end
                  nvs_pkg::s_addr: begin
                    step <= rd ? nvs_pkg::s_slave_r : nvs_pkg::s_data_w;
                    state <= rd ? nvs_pkg::h_start : nvs_pkg::h_wait;
                  end
                  nvs_pkg::s_data_w: begin
                    cnt <= cnt - 3'h1;
                    state <= (cnt == 3'h1) ? nvs_pkg::h_stop : nvs_pkg::h_wait;
                  end
                  nvs_pkg::s_slave_r: step <= nvs_pkg::s_data_r;
                  default: begin
                    o_rdata <= rx;
                    o_rdata_valid <= 1'h1;
                    cnt <= cnt - 3'h1;
                    if (cnt == 3'h1) begin
                      state <= nvs_pkg::h_stop;
                    end
                  end
                endcase
              end
            end
          end
        end
        default: state <= nvs_pkg::h_idle;
      endcase
    end
  end
endmodule : nvs_host

//--- tb/nvs_chk.sv
// Checker watching the two-wire link between host and device.
`timescale 1ns/1ns
module nvs_chk #(
  parameter logic [6:0] SLV = 7'h29
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_addr_sel,
  input wire logic scl,
  input wire logic serial_data_out_oe,
  input wire logic serial_data_in,
  input wire logic nonvolatile_select_bit
);
  logic scl_q, sda_q, in_frame, first, seen;
  logic [3:0] bcnt;
  logic [7:0] sh;
  logic [9:0] per;
  wire logic rise = scl && !scl_q;
  wire logic start = scl && scl_q && sda_q && !serial_data_in;
  wire logic stop = scl && scl_q && !sda_q && serial_data_in;
  wire logic nine = rise && bcnt == 4'h8;
  wire logic other = nine && first && sh[7:1] != {SLV[6:1], i_addr_sel};
  always_ff @(posedge i_core_clk) begin
    scl_q <= scl;
    sda_q <= serial_data_in;
    if (rise) sh <= {sh[6:0], serial_data_in};
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || start) begin
      bcnt <= 4'h0;
      first <= start;
      in_frame <= start;
    end else begin
      if (stop) in_frame <= 1'b0;
      if (rise) bcnt <= nine ? 4'h0 : bcnt + 4'h1;
      if (nine) first <= 1'b0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      per <= 10'h000;
      seen <= 1'b0;
    end else begin
      per <= rise ? 10'h001 : per + {9'h000, per != 10'h3FF};
      seen <= seen || rise;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_scl_period: assert property (rise && seen |-> per >= 10'd250)
    else $error("clock period too short");
  a_drive_low: assert property ($changed(serial_data_out_oe) |-> !scl)
    else $error("device data moved while clock high");
  a_idle_quiet: assert property (!in_frame |-> !serial_data_out_oe)
    else $error("device drove outside a frame");
  a_slave_nack: assert property (other |-> !serial_data_out_oe)
    else $error("foreign slave byte acknowledged");
  a_stop_free: assert property (stop |-> (!serial_data_out_oe)[*8])
    else $error("device drove after stop");
  a_start_free: assert property (start |-> (!serial_data_out_oe)[*8])
    else $error("device drove after start");
  a_select_hold: assert property (in_frame && $past(in_frame)
    |-> $stable(nonvolatile_select_bit))
    else $error("select bit moved in a frame");
  a_ack_held: assert property ($rose(serial_data_out_oe)
    |=> (serial_data_out_oe)[*8])
    else $error("device drive too short");
  c_ack: cover property (nine && first && serial_data_out_oe);
  c_nack: cover property (other);
  c_stop: cover property (stop);
endmodule : nvs_chk

//--- tb/tb_top.sv
// Bench joining host and device across the link.
`timescale 1ns/1ns
`include "nvs_defines.svh"
module tb_top;
  localparam logic [6:0] SLV = {`NVS_SLAVE_BASE, 1'b1};
  localparam int WLEFT = `NVS_WCYC_CYC - 2 * `NVS_SCL_QTR_CYC;
  logic i_core_clk, i_rst_n, i_nv_we, i_req_valid, i_req_read, i_req_nv;
  logic i_wdata_valid, o_req_ready, o_wdata_ready, o_rdata_valid, o_nack;
  logic o_done, o_cfg_valid, o_recall_done, o_ecc_corrected;
  logic o_ecc_uncorrectable, o_busy, i_addr_sel;
  logic [3:0] i_nv_addr, i_cfg_addr;
  logic [12:0] i_nv_word;
  logic [6:0] i_req_slave;
  logic [7:0] i_req_addr, i_wdata, o_rdata, o_cfg_data;
  logic [2:0] i_req_count;
  logic [7:0] arr [16];
  logic [7:0] shd [16];
  logic [7:0] d [4];
  logic [7:0] rq [$];
  int fails, num_checks, k;
  nvs_if i_nvs_if ();
  nvs_host i_nvs_host (.i_core_clk, .i_rst_n, .bus(i_nvs_if), .i_req_valid,
    .o_req_ready, .i_req_read, .i_req_nv, .i_req_slave, .i_req_addr,
    .i_req_count, .i_wdata_valid, .o_wdata_ready, .i_wdata, .o_rdata_valid,
    .o_rdata, .o_nack, .o_done);
  nvs_device i_nvs_device (.i_core_clk, .i_rst_n, .bus(i_nvs_if),
    .i_addr_sel, .i_nv_we, .i_nv_addr, .i_nv_word, .i_cfg_addr,
    .o_cfg_data, .o_cfg_valid, .o_recall_done, .o_ecc_corrected,
    .o_ecc_uncorrectable, .o_busy);
  nvs_chk #(.SLV(SLV)) i_nvs_chk (.i_core_clk, .i_rst_n, .i_addr_sel,
    .scl(i_nvs_if.scl), .serial_data_out_oe(i_nvs_if.serial_data_out_oe),
    .serial_data_in(i_nvs_if.serial_data_in),
    .nonvolatile_select_bit(i_nvs_if.nonvolatile_select_bit));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  function automatic logic [12:0] enc(input logic [7:0] v);
    logic [12:0] c;
    c = 13'h0000;
    {c[12:9], c[7:5], c[3]} = v;
    for (int p = 1; p < 16; p = p * 2) begin
      for (int j = 3; j < 13; j++) begin
        if ((j & p) != 0) c[p] = c[p] ^ c[j];
      end
    end
    c[0] = ^c[12:1];
    return c;
  endfunction : enc
  task automatic req(input logic rd, nv, input logic [6:0] sl,
                     input logic [7:0] a, input logic [2:0] n);
    int j;
    rq.delete();
    i_req_valid <= 1'b1;
    i_req_read <= rd;
    i_req_nv <= nv;
    i_req_slave <= sl;
    i_req_addr <= a;
    i_req_count <= n;
    for (j = 0; j < 40000; j++) begin
      @(posedge i_core_clk);
      if (o_done === 1'b1) break;
      if (o_rdata_valid === 1'b1) rq.push_back(o_rdata);
      if (o_req_ready === 1'b1) i_req_valid <= 1'b0;
    end
    if (j == 40000) begin
      fails++;
      end_sim();
    end
  endtask : req
  task automatic wpage(input logic nv, input logic [7:0] a);
    int j;
    i_wdata_valid <= 1'b1;
    for (j = 0; j < 5; j++) begin
      i_wdata <= (j < 4) ? d[j[1:0]] : 8'hA5;
      @(posedge i_core_clk);
      chk(o_wdata_ready, j < 4);
    end
    i_wdata_valid <= 1'b0;
    req(1'b0, nv, SLV, a, 3'd4);
  endtask : wpage
  task automatic cfg_chk;
    for (int j = 0; j < 16; j++) begin
      i_cfg_addr <= 4'(j);
      repeat (2) @(posedge i_core_clk);
      chk(o_cfg_data, shd[j]);
    end
  endtask : cfg_chk
  initial begin
    fails = 0;
    num_checks = 0;
    void'($urandom(88));
    {i_rst_n, i_nv_we, i_req_valid, i_req_read, i_req_nv} = 5'h00;
    i_addr_sel = 1'b1;
    {i_wdata_valid, i_nv_addr, i_cfg_addr, i_nv_word} = 22'h0;
    {i_req_slave, i_req_addr, i_wdata, i_req_count} = 26'h0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (k = 0; k < 16; k++) begin
      arr[k] = 8'($urandom);
      shd[k] = (k == 2 || k > 11) ? 8'h00 : arr[k];
      i_nv_we <= 1'b1;
      i_nv_addr <= 4'(k);
      i_nv_word <= enc(arr[k]) ^ (k == 1 ? 13'h20 : k == 2 ? 13'h30 : 13'h0);
      @(posedge i_core_clk);
    end
    i_nv_we <= 1'b0;
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (14) @(posedge i_core_clk);
    chk(o_recall_done, 1'b1);
    chk(o_cfg_valid, 1'b0);
    cfg_chk();
    for (k = 0; k < 4; k++) d[k] = 8'($urandom);
    d[0] = 8'h80;
    wpage(1'b0, 8'h02);
    for (k = 0; k < 4; k++) shd[(k + 2) % 4] = d[k];
    chk(o_nack, 1'b0);
    chk(o_busy, 1'b0);
    cfg_chk();
    for (k = 0; k < 4; k++) d[k] = 8'($urandom);
    wpage(1'b1, 8'h04);
    for (k = 0; k < 4; k++) arr[k + 4] = d[k];
    repeat (3) @(posedge i_core_clk);
    chk(o_busy, 1'b1);
    for (k = 0; k < 1100 && o_busy === 1'b1; k++) @(posedge i_core_clk);
    chk(16'(k > WLEFT - 8 && k < WLEFT + 8), 16'h1);
    cfg_chk();
    req(1'b1, 1'b1, SLV, 8'h04, 3'd3);
    chk(16'(rq.size()), 16'h3);
    for (k = 0; k < 3; k++) chk(rq[k], arr[k + 4]);
    chk({o_ecc_corrected, o_ecc_uncorrectable}, 2'b00);
    req(1'b1, 1'b1, SLV, 8'h02, 3'd1);
    chk({o_ecc_corrected, o_ecc_uncorrectable}, 2'b01);
    req(1'b1, 1'b1, SLV, 8'h01, 3'd1);
    chk(rq[0], arr[1]);
    chk({o_ecc_corrected, o_ecc_uncorrectable}, 2'b10);
    req(1'b1, 1'b0, SLV ^ 7'h01, 8'h03, 3'd1);
    chk(o_nack, 1'b1);
    chk(16'(rq.size()), 16'h0);
    i_addr_sel <= 1'b0;
    req(1'b1, 1'b0, SLV ^ 7'h01, 8'h03, 3'd1);
    chk(o_nack, 1'b0);
    chk(rq[0], shd[3]);
    end_sim();
  end
endmodule : tb_top
